// [ddc_cfg_pkg.sv]
// constants for the channel gain and serial configuration block
package ddc_cfg_pkg;
    // register indices (byte address = 4 * index)
    localparam logic [7:0] IDX_LOOP_CTRL = 8'h12;
    localparam logic [7:0] IDX_GAIN_A = 8'h14;
    localparam logic [7:0] IDX_GAIN_B = 8'h15;
    localparam logic [7:0] IDX_UP_LIMIT = 8'h16;
    localparam logic [7:0] IDX_LO_LIMIT = 8'h17;
    localparam logic [7:0] IDX_SER_FRAME = 8'h18;
    localparam logic [7:0] IDX_SER_CLKPIN = 8'h19;
    localparam logic [7:0] IDX_DATAPATH = 8'h1A;
    localparam logic [7:0] IDX_CHAN_CTRL = 8'h1B;
    localparam logic [7:0] IDX_STATUS = 8'h1C;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // field positions
    localparam int FREEZE_BIT = 12;
    localparam int FSINVL_LSB = 8;
    localparam int CLKDIV_LSB = 12;
    localparam int WIDE_BIT = 7;
    localparam int ALT_BIT = 6;
    localparam int RNDDIS_BIT = 11;
    localparam int GMON_BIT = 10;
    localparam int RATE_LSB = 8;
    localparam int MUXB_LSB = 4;
    localparam int REMIX_BIT = 3;
    localparam int BYPASS_BIT = 2;
    localparam int ENA_BIT = 0;
    localparam int CDMA_BIT = 1;
    localparam int MUXA_LSB = 4;
    localparam int SSEL_LSB = 8;
    localparam int GAIN_W = 24;
    localparam logic [23:0] UNITY_GAIN = 24'h001000;
    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_DELAY = 2'b01,
        SER_SHIFT = 2'b10
    } ser_state_t;
endpackage

// [ddc_channel_gain_serial_config.sv]
// one downconverter channel: gain, limits, serial output and datapath configuration
// ****************************************
// Notes on behaviour
// ****************************************
// Notes on behaviour
// RL1: gain is 24-bit unsigned, 12.12 format
// RL2: gain A for UMTS/A, gain B for B
// RL3: 0x001000 means unity gain
// RL4: written gains load on sync event
// RL5: adjusted gain capped at gain plus upper
// RL6: adjusted gain floored at gain minus lower
// RL7: frame syncs spaced by interval bit clocks (the code spaces them interval plus one bit clocks)
// RL8: sample bit count is field plus one
// RL9: serial clock divided by field plus one
// RL10: wide option gives four pins each
// RL11: alternate bit outputs neighbour Q data
// RL12: software pairs wide option with alternate
// RL13: MSB delayed 0-3 bit times after sync
// RL14: four-bit select routes I and Q inputs
// RL15: override keeps 29 bits, round bit 4
// RL16: gain monitor packs gain into samples
// RL17: two-bit code sets input rate
// RL18: remix-only forces Q to zero
// RL19: bypass feeds buses into compensation filter
// RL20: even channel chains into odd neighbour
// RL21: odd channel takes neighbour input when set
// RL22: software programs pair codes 10 and 01
// RL23: cleared enable stops channel clocks
// RL24: gain load event from selected sync
// RL25: freeze holds automatic gain value
`timescale 1ns/1ps
module ddc_channel_gain_serial_config #(
    parameter int SAMPLE_W = 18,
    parameter bit ODD_CHANNEL = 1'b0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sync inputs (pins) and agc adjust request
    input wire logic [3:0] sync_pins,
    input wire logic [15:0] agc_step,
    input wire logic agc_up,
    input wire logic agc_down,
    // sample inputs from the filter chain
    input wire logic [SAMPLE_W-1:0] own_i,
    input wire logic [SAMPLE_W-1:0] own_q,
    input wire logic [SAMPLE_W-1:0] neighbour_q,
    input wire logic [1:0] shift_status,
    input wire logic [28:0] agc_result,
    // converter inputs
    input wire logic [15:0] internal_converter_input,
    input wire logic [15:0] unused_input,
    input wire logic [15:0] external_input_one,
    input wire logic [15:0] external_input_two,
    // datapath controls
    output logic [15:0] mix_i_a,
    output logic [15:0] mix_q_a,
    output logic [15:0] mix_i_b,
    output logic [15:0] mix_q_b,
    output logic [15:0] comp_i,
    output logic [15:0] comp_q,
    output logic comp_sync,
    output logic comp_from_bypass,
    output logic [17:0] rounded_out,
    output logic input_rate_strobe,
    output logic channel_clk_enable,
    output logic chain_to_neighbour,
    output logic add_neighbour_sum,
    output logic pfir_from_neighbour,
    output logic [23:0] active_gain,
    // serial output
    output logic ser_clk,
    output logic ser_frame,
    output logic [3:0] ser_i_pins,
    output logic [3:0] ser_q_pins
);
    import ddc_cfg_pkg::*;

    typedef struct packed {
        logic [15:0] loop_ctrl, gain_a_low, gain_b_low, up_lim, lo_lim;
        logic [15:0] ser_frame_cfg, ser_clkpin_cfg, datapath, chan_ctrl;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [3:0] sync_m, sync_s;
        logic [23:0] buf_a, buf_b, act_a, act_b, adj_a;
        logic [3:0] div_cnt;
        logic [2:0] rate_cnt;
        logic [6:0] fs_cnt;
        logic [4:0] bit_cnt;
        logic [1:0] del_cnt;
        ser_state_t sst;
        logic [SAMPLE_W-1:0] sh_i, sh_q;
        logic ser_clk, ser_frame;
        logic [3:0] pin_i, pin_q;
        logic [15:0] mia, mqa, mib, mqb, ci, cq;
        logic csync, cbyp, rstrobe, clken, chain, addsum, fromnb;
        logic [17:0] rnd;
        logic [23:0] gain_out;
    } state_t;

    state_t cur, nxt;
    logic [7:0] idx;
    logic bit_en, sync_ev, oneshot;
    logic [24:0] hi_lim, lo_lim_v, cand;
    logic [SAMPLE_W-1:0] tx_i, tx_q, mon_i, mon_q;
    logic [15:0] in_sel [4];
    logic [28:0] rsum;
    logic [2:0] ssel;
    logic [3:0] sa, sb;
    int w;

    // mux one four-bit select into I/Q source indices
    function automatic logic [3:0] route(input logic [3:0] s);
        logic [1:0] i, q;
        i = 2'd0;
        q = 2'd0;
        if (s < 4'h4) begin
            i = s[1:0];
            q = s[1:0];
        end else begin
            i = 2'((s - 4'h4) / 4'h3);
            q = 2'((s - 4'h4) % 4'h3);
            if (q >= i) begin
                q = q + 2'd1;
            end
        end
        return {i, q};
    endfunction

    assign idx = paddr[9:2];
    assign in_sel[0] = internal_converter_input;
    assign in_sel[1] = unused_input;
    assign in_sel[2] = external_input_one;
    assign in_sel[3] = external_input_two;
    assign ssel = cur.chan_ctrl[SSEL_LSB +: 3];
    assign oneshot = psel && penable && pwrite && idx == IDX_CHAN_CTRL && pwdata[15];

    always_comb begin
        nxt = cur;
        w = 0;
        // apb: one wait-free access phase, unmapped reads zero with error
        nxt.pready = psel && !penable;
        nxt.pslverr = 1'b0;
        if (psel && !penable) begin
            nxt.prdata = 32'h0000_0000;
            case (idx)
                IDX_LOOP_CTRL: nxt.prdata[15:0] = cur.loop_ctrl;
                IDX_GAIN_A: nxt.prdata[15:0] = cur.gain_a_low;
                IDX_GAIN_B: nxt.prdata[15:0] = cur.gain_b_low;
                IDX_UP_LIMIT: nxt.prdata[15:0] = cur.up_lim;
                IDX_LO_LIMIT: nxt.prdata[15:0] = cur.lo_lim;
                IDX_SER_FRAME: nxt.prdata[15:0] = cur.ser_frame_cfg;
                IDX_SER_CLKPIN: nxt.prdata[15:0] = cur.ser_clkpin_cfg;
                IDX_DATAPATH: nxt.prdata[15:0] = cur.datapath;
                IDX_CHAN_CTRL: nxt.prdata[15:0] = {1'b0, cur.chan_ctrl[14:0]};
                IDX_STATUS: nxt.prdata[15:0] = cur.act_a[23:8];
                default: nxt.pslverr = 1'b1;
            endcase
        end
        if (psel && penable && cur.pready && pwrite) begin
            case (idx)
                IDX_LOOP_CTRL: nxt.loop_ctrl = pwdata[15:0];
                IDX_GAIN_A: nxt.gain_a_low = pwdata[15:0];
                IDX_GAIN_B: nxt.gain_b_low = pwdata[15:0];
                IDX_UP_LIMIT: nxt.up_lim = pwdata[15:0];
                IDX_LO_LIMIT: nxt.lo_lim = pwdata[15:0];
                IDX_SER_FRAME: nxt.ser_frame_cfg = pwdata[15:0];
                IDX_SER_CLKPIN: nxt.ser_clkpin_cfg = pwdata[15:0];
                IDX_DATAPATH: nxt.datapath = pwdata[15:0];
                IDX_CHAN_CTRL: nxt.chan_ctrl = {1'b0, pwdata[14:0]};
                default: nxt.pslverr = 1'b1;
            endcase
        end
        // sync pins through two flops
        nxt.sync_m = sync_pins;
        nxt.sync_s = cur.sync_m;
        // RL24: pick the gain load sync source
        case (ssel)
            3'h0, 3'h1, 3'h2, 3'h3: sync_ev = cur.sync_s[ssel[1:0]];
            3'h5: sync_ev = oneshot;
            3'h7: sync_ev = 1'b1;
            default: sync_ev = 1'b0;
        endcase
        // RL1: low 16 bits written, upper 8 held as zero
        nxt.buf_a = {8'h00, cur.gain_a_low};
        nxt.buf_b = {8'h00, cur.gain_b_low};
        // RL4: active gains load only on the sync event
        if (sync_ev) begin
            nxt.act_a = cur.buf_a;
            nxt.act_b = cur.buf_b;
            nxt.adj_a = cur.buf_a;
        end
        // RL5: upper bound gain plus upper limit
        hi_lim = {1'b0, cur.act_a} + {9'h000, cur.up_lim};
        // RL6: lower limit negated, floor at gain minus limit
        lo_lim_v = {1'b0, cur.act_a} - {9'h000, cur.lo_lim};
        if (lo_lim_v[24]) begin
            lo_lim_v = 25'h0000000;
        end
        cand = {1'b0, cur.adj_a};
        if (agc_up) begin
            cand = {1'b0, cur.adj_a} + {9'h000, agc_step};
        end else if (agc_down) begin
            cand = {1'b0, cur.adj_a} - {9'h000, agc_step};
            if (cand[24]) begin
                cand = 25'h0000000;
            end
        end
        if (cand > hi_lim) begin
            cand = hi_lim;
        end
        if (cand < lo_lim_v) begin
            cand = lo_lim_v;
        end
        // RL25: freeze holds the adjusted gain until the next sync event
        if (!cur.loop_ctrl[FREEZE_BIT] && !sync_ev) begin
            nxt.adj_a = cand[23:0];
        end
        // RL2: in cdma mode the B gain replaces the adjusted A gain on active_gain
        // RL3: unity gain passes through as 0x001000
        nxt.gain_out = cur.chan_ctrl[CDMA_BIT] ? cur.act_b : cur.adj_a;
        // RL23: enable bit gates the channel clock
        nxt.clken = cur.chan_ctrl[ENA_BIT];
        // RL17: input rate strobe every 1/2/4/8 cycles
        nxt.rate_cnt = cur.rate_cnt + 3'd1;
        case (cur.datapath[RATE_LSB +: 2])
            2'b00: nxt.rstrobe = 1'b1;
            2'b01: nxt.rstrobe = cur.rate_cnt[0];
            2'b10: nxt.rstrobe = &cur.rate_cnt[1:0];
            default: nxt.rstrobe = &cur.rate_cnt;
        endcase
        // RL14: input routing for A and B streams
        sa = route(cur.chan_ctrl[MUXA_LSB +: 4]);
        sb = route(cur.datapath[MUXB_LSB +: 4]);
        nxt.mia = in_sel[sa[3:2]];
        nxt.mqa = in_sel[sa[1:0]];
        nxt.mib = in_sel[sb[3:2]];
        nxt.mqb = in_sel[sb[1:0]];
        // RL18: remix-only zeroes the selected Q
        if (cur.datapath[REMIX_BIT]) begin
            nxt.mqa = 16'h0000;
            nxt.mqb = 16'h0000;
        end
        // RL19: bypass feeds first/second bus to compensation filter
        nxt.cbyp = cur.datapath[BYPASS_BIT];
        nxt.ci = internal_converter_input;
        nxt.cq = unused_input;
        nxt.csync = cur.datapath[BYPASS_BIT] && internal_converter_input[0];
        // RL15: override keeps 29 bits and rounds at bit 4
        rsum = cur.datapath[RNDDIS_BIT] ? agc_result + 29'h0000010
            : agc_result + (29'h0000001 << (5'd10 + 5'(cur.loop_ctrl[3:0])));
        nxt.rnd = cur.datapath[RNDDIS_BIT] ? rsum[22:5] : rsum[28:11];
        // RL20: even channel chains out and adds the partial sum
        nxt.chain = !ODD_CHANNEL && cur.datapath[1];
        nxt.addsum = !ODD_CHANNEL && cur.datapath[1];
        // RL21: odd channel input from main filter when set
        nxt.fromnb = ODD_CHANNEL && cur.datapath[0];
        // RL9: serial bit enable every clkdiv+1 cycles
        bit_en = cur.div_cnt >= cur.ser_clkpin_cfg[CLKDIV_LSB +: 4];
        nxt.div_cnt = bit_en ? 4'h0 : cur.div_cnt + 4'h1;
        if (bit_en) begin
            nxt.ser_clk = 1'b1;
        end else if (cur.div_cnt == (cur.ser_clkpin_cfg[CLKDIV_LSB +: 4] >> 1)) begin
            nxt.ser_clk = 1'b0;
        end
        // RL16: gain monitor packing
        mon_i = {own_i[17:10], cur.adj_a[18:11], 2'b00};
        mon_q = {own_q[17:10], cur.adj_a[10:5], shift_status, 2'b00};
        // RL11: alternate output carries neighbour Q
        tx_q = cur.datapath[GMON_BIT] ? mon_q : own_q;
        tx_i = cur.datapath[GMON_BIT] ? mon_i : own_i;
        if (cur.ser_clkpin_cfg[ALT_BIT]) begin
            tx_i = neighbour_q;
            tx_q = neighbour_q;
        end
        if (bit_en) begin
            nxt.ser_frame = 1'b0;
            // RL7: frame sync every interval plus one bit clocks
            nxt.fs_cnt = cur.fs_cnt + 7'd1;
            if (cur.fs_cnt >= cur.ser_frame_cfg[FSINVL_LSB +: 7]) begin
                nxt.fs_cnt = 7'd0;
                nxt.ser_frame = cur.clken;
                nxt.sst = SER_DELAY;
                nxt.del_cnt = cur.ser_clkpin_cfg[1:0];
                nxt.sh_i = tx_i;
                nxt.sh_q = tx_q;
                nxt.bit_cnt = 5'd0;
            end else begin
                case (cur.sst)
                    // RL13: delay 0..3 bit times, MSB stands in the last one
                    SER_DELAY, SER_SHIFT: begin
                        if (cur.sst == SER_DELAY && cur.del_cnt != 2'd0) begin
                            nxt.del_cnt = cur.del_cnt - 2'd1;
                        end else begin
                            nxt.sst = SER_SHIFT;
                            // RL10: four or two pins per component
                            w = cur.ser_clkpin_cfg[WIDE_BIT] ? 4 : 2;
                            nxt.sh_i = cur.sh_i << w;
                            nxt.sh_q = cur.sh_q << w;
                            // RL8: stop after bits field plus one
                            nxt.bit_cnt = cur.bit_cnt + 5'(w);
                            if (32'(cur.bit_cnt) + w > 32'(cur.ser_frame_cfg[4:0])) begin
                                nxt.sst = SER_IDLE;
                            end
                        end
                    end
                    default: nxt.sst = SER_IDLE;
                endcase
            end
        end
        if (cur.sst == SER_SHIFT || (cur.sst == SER_DELAY && cur.del_cnt == 2'd0)) begin
            nxt.pin_i = cur.ser_clkpin_cfg[WIDE_BIT] ? cur.sh_i[SAMPLE_W-1 -: 4]
                : {2'b00, cur.sh_i[SAMPLE_W-1 -: 2]};
            nxt.pin_q = cur.ser_clkpin_cfg[WIDE_BIT] ? cur.sh_q[SAMPLE_W-1 -: 4]
                : {2'b00, cur.sh_q[SAMPLE_W-1 -: 2]};
        end else begin
            nxt.pin_i = 4'h0;
            nxt.pin_q = 4'h0;
        end
    end

    // register the whole state
    always_ff @(posedge mclk) begin
        if (reset) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end

    assign prdata = cur.prdata;
    assign pready = cur.pready;
    assign pslverr = cur.pslverr;
    assign mix_i_a = cur.mia;
    assign mix_q_a = cur.mqa;
    assign mix_i_b = cur.mib;
    assign mix_q_b = cur.mqb;
    assign comp_i = cur.ci;
    assign comp_q = cur.cq;
    assign comp_sync = cur.csync;
    assign comp_from_bypass = cur.cbyp;
    assign rounded_out = cur.rnd;
    assign input_rate_strobe = cur.rstrobe;
    assign channel_clk_enable = cur.clken;
    assign chain_to_neighbour = cur.chain;
    assign add_neighbour_sum = cur.addsum;
    assign pfir_from_neighbour = cur.fromnb;
    assign active_gain = cur.gain_out;
    assign ser_clk = cur.ser_clk;
    assign ser_frame = cur.ser_frame;
    assign ser_i_pins = cur.pin_i;
    assign ser_q_pins = cur.pin_q;

    // RL5: adjusted gain never above upper bound
    chk_gain_upper: assert property (@(posedge mclk) disable iff (reset) // RL5
        !$past(sync_ev) && !$past(cur.loop_ctrl[FREEZE_BIT]) |-> cur.adj_a <= 24'($past(hi_lim)))
        else $error("gain above upper limit");
    // RL25: frozen gain stays constant
    chk_freeze_hold: assert property (@(posedge mclk) disable iff (reset) // RL25
        cur.loop_ctrl[FREEZE_BIT] && !sync_ev && nxt.loop_ctrl[FREEZE_BIT] |=> $stable(cur.adj_a))
        else $error("gain moved while frozen");
    // RL4: active gain changes only after a sync
    chk_gain_load: assert property (@(posedge mclk) disable iff (reset) // RL4
        !sync_ev |=> $stable(cur.act_a))
        else $error("active gain changed without sync");
    // RL18: remix-only zeroes Q
    chk_remix_zero: assert property (@(posedge mclk) disable iff (reset) // RL18
        cur.datapath[REMIX_BIT] |=> cur.mqa == 16'h0000 && cur.mqb == 16'h0000)
        else $error("Q not zero in remix mode");
    // RL23: clock enable low the cycle after the enable bit is clear
    chk_clk_enable: assert property (@(posedge mclk) disable iff (reset) // RL23
        !cur.chan_ctrl[ENA_BIT] |=> !channel_clk_enable)
        else $error("clock enabled while disabled");
    // RL21: odd channel source follows lower bit
    chk_odd_source: assert property (@(posedge mclk) disable iff (reset) // RL21
        ##1 pfir_from_neighbour == (ODD_CHANNEL && $past(cur.datapath[0])))
        else $error("filter source wrong");
    // RL20: even channel chaining follows upper bit
    chk_even_chain: assert property (@(posedge mclk) disable iff (reset) // RL20
        ##1 chain_to_neighbour == (!ODD_CHANNEL && $past(cur.datapath[1])))
        else $error("chain control wrong");
    // RL9: divider count never exceeds the divider field
    chk_div_count: assert property (@(posedge mclk) disable iff (reset) // RL9
        $stable(cur.ser_clkpin_cfg) |-> cur.div_cnt <= cur.ser_clkpin_cfg[CLKDIV_LSB +: 4])
        else $error("divider overran");
endmodule

// [ser_sink.sv]
// model of the baseband processor that takes the serial samples
`timescale 1ns/1ps
module ser_sink (
    // clock
    input wire logic mclk,
    // serial link from the channel
    input wire logic ser_clk,
    input wire logic ser_frame,
    input wire logic [3:0] ser_i_pins,
    input wire logic [3:0] ser_q_pins,
    // measurements for the bench
    output int frame_gap,
    output int frame_count,
    output logic [17:0] last_word
);
    int since = 0;
    logic frame_d = 1'b0;
    logic clk_d = 1'b0;
    // time frame rises in clock cycles and shift in the two low i pins
    always @(posedge mclk) begin
        frame_d <= ser_frame;
        clk_d <= ser_clk;
        if (ser_clk === 1'b1 && clk_d === 1'b0) begin
            last_word <= {last_word[15:0], ser_i_pins[1:0]};
        end
        if (ser_frame === 1'b1 && frame_d === 1'b0) begin
            frame_gap <= since + 1;
            frame_count <= frame_count + 1;
            since <= 0;
        end else begin
            since <= since + 1;
        end
    end
endmodule

// [ddc_channel_gain_serial_config_tb.sv]
// self-checking bench for the channel gain and serial configuration block
`timescale 1ns/1ps
module ddc_channel_gain_serial_config_tb;
    import ddc_cfg_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    logic [15:0] agc_step = 16'h0000;
    logic agc_up = 1'b0;
    logic agc_down = 1'b0;
    logic [17:0] smp = 18'h2ABCD;
    logic [15:0] bus [4] = '{16'hA0A0, 16'hB1B1, 16'hC2C2, 16'hD3D3};
    logic [15:0] mix_i_a, mix_q_a, mix_i_b, mix_q_b, comp_i, comp_q;
    logic comp_sync, comp_from_bypass, input_rate_strobe, channel_clk_enable;
    logic chain_to_neighbour, add_neighbour_sum, pfir_from_neighbour, ser_clk, ser_frame;
    logic [17:0] rounded_out, word;
    logic [23:0] active_gain;
    logic [3:0] ser_i_pins, ser_q_pins;
    logic [7:0] regs [8] = '{IDX_LOOP_CTRL, IDX_GAIN_A, IDX_GAIN_B, IDX_UP_LIMIT,
        IDX_LO_LIMIT, IDX_SER_FRAME, IDX_SER_CLKPIN, IDX_DATAPATH};
    int isrc [16] = '{0, 1, 2, 3, 0, 0, 0, 1, 1, 1, 2, 2, 2, 3, 3, 3};
    int qsrc [16] = '{0, 1, 2, 3, 1, 2, 3, 0, 2, 3, 0, 1, 3, 0, 1, 2};
    int divs [3] = '{0, 3, 15};
    int n_fail = 0;
    int tests_run = 0;
    int gap, fcount, cnt, n;
    // 200 MHz clock
    always #2.5 mclk = ~mclk;
    ddc_channel_gain_serial_config dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sync_pins(4'h0), .agc_step(agc_step), .agc_up(agc_up), .agc_down(agc_down),
        .own_i(smp), .own_q(~smp), .neighbour_q(smp ^ 18'h3F00F), .shift_status(smp[1:0]),
        .agc_result({11'h000, smp}), .internal_converter_input(bus[0]), .unused_input(bus[1]),
        .external_input_one(bus[2]), .external_input_two(bus[3]), .mix_i_a(mix_i_a), .mix_q_a(mix_q_a),
        .mix_i_b(mix_i_b), .mix_q_b(mix_q_b), .comp_i(comp_i), .comp_q(comp_q), .comp_sync(comp_sync),
        .comp_from_bypass(comp_from_bypass), .rounded_out(rounded_out),
        .input_rate_strobe(input_rate_strobe), .channel_clk_enable(channel_clk_enable),
        .chain_to_neighbour(chain_to_neighbour), .add_neighbour_sum(add_neighbour_sum),
        .pfir_from_neighbour(pfir_from_neighbour), .active_gain(active_gain), .ser_clk(ser_clk),
        .ser_frame(ser_frame), .ser_i_pins(ser_i_pins), .ser_q_pins(ser_q_pins));
    ser_sink sink (.mclk(mclk), .ser_clk(ser_clk), .ser_frame(ser_frame), .ser_i_pins(ser_i_pins),
        .ser_q_pins(ser_q_pins), .frame_gap(gap), .frame_count(fcount), .last_word(word));
    // one apb transfer, held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
        int k = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {16'h0000, wd};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && k < 50) begin
            @(posedge mclk);
            k++;
        end
        if (k == 50) n_fail++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 16'h0000);
        check("register read", rd, exp);
    endtask
    task automatic settle();
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task automatic pulse_adj(input logic up);
        @(posedge mclk);
        agc_step <= 16'h0800;
        agc_up <= up;
        agc_down <= ~up;
        repeat (4) @(posedge mclk);
        agc_up <= 1'b0;
        agc_down <= 1'b0;
        settle();
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // watchdog well beyond the expected run length
    initial begin
        repeat (30000) @(posedge mclk);
        n_fail++;
        summarize();
    end
    initial begin
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        // ****************************************
        // registers, unmapped index
        // ****************************************
        foreach (regs[k]) rchk(regs[k], 32'h00000000);
        foreach (regs[k]) apb(1'b1, regs[k], 16'h5A5A ^ 16'(k));
        foreach (regs[k]) rchk(regs[k], 32'(16'h5A5A ^ 16'(k)));
        foreach (regs[k]) apb(1'b1, regs[k], 16'h0000);
        apb(1'b1, 8'h13, 16'hFFFF);
        check("unmapped write error", 32'(err), 32'h00000001);
        rchk(8'h13, 32'h00000000);
        check("unmapped read error", 32'(err), 32'h00000001);
        $display("test registers done");
        // ****************************************
        // double-buffered gain, limits, freeze
        // ****************************************
        apb(1'b1, IDX_CHAN_CTRL, 16'h0501);
        apb(1'b1, IDX_UP_LIMIT, 16'h0200);
        apb(1'b1, IDX_LO_LIMIT, 16'h0100);
        apb(1'b1, IDX_GAIN_A, 16'h1000);
        settle();
        check("gain before sync", 32'(active_gain), 32'h00000000);
        apb(1'b1, IDX_CHAN_CTRL, 16'h8501);
        settle();
        check("gain after sync", 32'(active_gain), 32'(UNITY_GAIN));
        rchk(IDX_STATUS, 32'h00000010);
        pulse_adj(1'b1);
        check("gain upper cap", 32'(active_gain), 32'h00001200);
        pulse_adj(1'b0);
        check("gain lower floor", 32'(active_gain), 32'h00000F00);
        apb(1'b1, IDX_LOOP_CTRL, 16'h1000);
        pulse_adj(1'b1);
        check("gain frozen", 32'(active_gain), 32'h00000F00);
        apb(1'b1, IDX_LOOP_CTRL, 16'h0000);
        $display("test gain done");
        // ****************************************
        // mixer input select, remix, bypass
        // ****************************************
        for (int k = 0; k < 16; k++) begin
            apb(1'b1, IDX_CHAN_CTRL, 16'h0501 | 16'(k << 4));
            apb(1'b1, IDX_DATAPATH, 16'(k << 4));
            settle();
            check("mix a i", 32'(mix_i_a), 32'(bus[isrc[k]]));
            check("mix a q", 32'(mix_q_a), 32'(bus[qsrc[k]]));
            check("mix b i", 32'(mix_i_b), 32'(bus[isrc[k]]));
            check("mix b q", 32'(mix_q_b), 32'(bus[qsrc[k]]));
        end
        apb(1'b1, IDX_CHAN_CTRL, 16'h0553);
        apb(1'b1, IDX_DATAPATH, 16'h0058);
        settle();
        check("remix q zero", 32'(mix_q_a), 32'h00000000);
        apb(1'b1, IDX_DATAPATH, 16'h0004);
        settle();
        check("bypass flag", 32'(comp_from_bypass), 32'h00000001);
        check("bypass i", 32'(comp_i), 32'(bus[0]));
        check("bypass q", 32'(comp_q), 32'(bus[1]));
        check("bypass sync", 32'(comp_sync), 32'(bus[0][0]));
        apb(1'b1, IDX_DATAPATH, 16'h0800);
        settle();
        check("round override", 32'(rounded_out), 32'h0000155E);
        $display("test datapath done");
        // ****************************************
        // input rate, chaining, enable
        // ****************************************
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, IDX_DATAPATH, 16'(c << 8));
            settle();
            cnt = 0;
            repeat (64) begin
                @(posedge mclk);
                #1;
                if (input_rate_strobe === 1'b1) cnt++;
            end
            check("rate strobes", 32'(cnt), 32'(64 >> c));
        end
        apb(1'b1, IDX_DATAPATH, 16'h0002);
        settle();
        check("chain out", 32'(chain_to_neighbour), 32'h00000001);
        check("add sum", 32'(add_neighbour_sum), 32'h00000001);
        apb(1'b1, IDX_DATAPATH, 16'h0001);
        settle();
        check("even never takes", 32'(pfir_from_neighbour), 32'h00000000);
        check("enable on", 32'(channel_clk_enable), 32'h00000001);
        apb(1'b1, IDX_CHAN_CTRL, 16'h0500);
        settle();
        check("enable off", 32'(channel_clk_enable), 32'h00000000);
        $display("test control done");
        // ****************************************
        // serial frame spacing versus divider
        // ****************************************
        apb(1'b1, IDX_CHAN_CTRL, 16'h0501);
        apb(1'b1, IDX_SER_FRAME, 16'h0F11);
        foreach (divs[k]) begin
            apb(1'b1, IDX_SER_CLKPIN, 16'(divs[k] << 12));
            cnt = fcount;
            n = 0;
            while (fcount < cnt + 3 && n < 5000) begin
                @(posedge mclk);
                n++;
            end
            check("frame gap", 32'(gap), 32'(16 * (divs[k] + 1)));
        end
        // wide option stays cleared, no partner needed
        apb(1'b1, IDX_SER_FRAME, 16'h0811);
        for (int a = 0; a < 2; a++) begin
            apb(1'b1, IDX_SER_CLKPIN, 16'h1000 | 16'(a << ALT_BIT));
            cnt = fcount;
            while (fcount < cnt + 3) @(posedge mclk);
            check("serial word", 32'(word), 32'(a ? smp ^ 18'h3F00F : smp));
        end
        $display("test serial done");
        summarize();
    end
endmodule
